// >>> mcl_pkg.sv
// constants, types and state record of the master clock and low-power controller
// ****************************************************************************
// How it works
// - main system clock is divided main pll output or crystal clock, by pll select
// - missing-clock detector on fast internal clock substitutes it for main clock
// - clock failure raises a flag toward nmi logic and control subsystem
// - master owns main pll writes; slave requests ownership, master requests back
// - exactly one of run, sleep, deep sleep; plls and clocks run in run and sleep
// - master clock is system clock divided by master divider, fast clock divided by master divider on failure
// - pll bypassed: system clock is oscillator divided by system divider
// - analog clock is system clock divided by analog divider, undivided fast on failure
// - deep sleep clock: slow, fast or osc, deep divider, then master divider
// - internal deep-sleep source chosen: oscillator powered off during deep sleep
// - run: usb from usb pll, can selectable, first watchdog from oscillator
// - gating applies only to peripherals marked present
// - wait-for-interrupt stops cpu clock, enters deep sleep or sleep by select bit
// - any enabled interrupt ends sleep or deep sleep, back to run
// - sleep: cpu and memory unclocked; gating from run or sleep set by auto-gating
// - sleep peripherals get same clock rate as in run
// - sleep-on-exit set: run only waking handler then return to same low-power mode
// - deep sleep: cpu, memory, plls, analog, control and shared clocks off
// - deep sleep gating from run or deep set by auto-gating
// - six-bit usb multiplier code multiplies by its binary value, 32 to 63 included
// - usb multiplier code zero bypasses pll, input clock straight to usb clock
// ****************************************************************************
package mcl_pkg;

  localparam int DIV_W = 6;
  localparam int N_PERIPH = 8;
  localparam int MISS_W = 8;
  localparam logic [MISS_W-1:0] MISS_FAST_TICKS = 8'h08;
  localparam logic [DIV_W-1:0] USB_PLL_DIV = 6'h04;
  localparam logic [DIV_W-1:0] DIV_ONE = 6'h01;
  localparam int USB_MULT_W = 6;
  localparam logic [USB_MULT_W-1:0] USB_MULT_BYPASS = 6'h00;

  typedef enum logic [1:0] {
    MCL_RUN = 2'b00,
    MCL_SLEEP = 2'b01,
    MCL_DEEP = 2'b10
  } mcl_mode_t;

  typedef enum logic [1:0] {
    MCL_DS_SLOW = 2'b00,
    MCL_DS_FAST = 2'b01,
    MCL_DS_OSC = 2'b10
  } mcl_ds_src_t;

  typedef enum logic [1:0] {
    MCL_CAN_MASTER = 2'b00,
    MCL_CAN_OSC = 2'b01,
    MCL_CAN_AUX = 2'b10
  } mcl_can_src_t;

  // source clocks, each one ref_clk cycle high per source edge
  typedef struct packed {
    logic main_pll;
    logic oscillator;
    logic fast_osc;
    logic slow_osc;
    logic aux_in;
    logic usb_pll;
    logic usb_ref;
  } mcl_ticks_t;

  // derived clock enables, one ref_clk cycle high per derived edge
  typedef struct packed {
    logic main_system;
    logic master_subsystem;
    logic analog_subsystem;
    logic master_cpu;
    logic slave_and_shared;
    logic can;
    logic first_watchdog;
    logic usb;
  } mcl_clocks_t;

  typedef struct packed {
    logic [DIV_W-1:0] cnt;
    logic pulse;
  } mcl_div_t;

  typedef struct packed {
    mcl_mode_t mode;
    mcl_mode_t return_mode;
    logic isr_temp;
    logic owner_slave;
    logic fail;
    logic [MISS_W-1:0] miss_cnt;
    logic sys_sel_pll;
    logic [1:0] ds_sel;
    logic [1:0] can_sel;
    logic [DIV_W-1:0] sys_cnt;
    logic [DIV_W-1:0] mst_cnt;
    logic [DIV_W-1:0] ana_cnt;
    logic [DIV_W-1:0] ds_cnt;
    logic [DIV_W-1:0] usb_cnt;
    mcl_clocks_t clk;
    logic [N_PERIPH-1:0] periph;
    logic main_pll_on;
    logic usb_pll_on;
    logic osc_on;
    logic usb_bypass;
    logic [USB_MULT_W-1:0] usb_mult;
    logic pll_wr_accept;
  } mcl_state_t;

endpackage : mcl_pkg

// >>> mcl_clock_lowpower.sv
// master subsystem clock selection, dividers, gating and low-power sequencing
`timescale 1ns/1ps
module mcl_clock_lowpower
(
  input wire logic ref_clk,
  input wire logic srst,
  input wire mcl_pkg::mcl_ticks_t ticks,
  input wire logic main_pll_output_select,
  input wire logic [mcl_pkg::DIV_W-1:0] system_clock_divider_select,
  input wire logic [mcl_pkg::DIV_W-1:0] master_clock_divider_select,
  input wire logic [mcl_pkg::DIV_W-1:0] analog_clock_divider_control,
  input wire logic [1:0] deep_sleep_source_select,
  input wire logic [mcl_pkg::DIV_W-1:0] deep_sleep_divider,
  input wire logic [1:0] can_source_select,
  input wire logic [mcl_pkg::USB_MULT_W-1:0] usb_pll_integer_multiplier,
  input wire logic [mcl_pkg::N_PERIPH-1:0] run_peripheral_gating,
  input wire logic [mcl_pkg::N_PERIPH-1:0] sleep_peripheral_gating,
  input wire logic [mcl_pkg::N_PERIPH-1:0] deep_sleep_peripheral_gating,
  input wire logic [mcl_pkg::N_PERIPH-1:0] device_configuration_presence,
  input wire logic auto_gating_select,
  input wire logic deep_sleep_select_bit,
  input wire logic sleep_on_exit_bit,
  input wire logic wait_for_interrupt,
  input wire logic wake_interrupt,
  input wire logic isr_return,
  input wire logic slave_write_ownership_request,
  input wire logic master_write_ownership_request,
  input wire logic master_pll_write,
  input wire logic slave_pll_write,
  output mcl_pkg::mcl_clocks_t clocks,
  output logic [mcl_pkg::N_PERIPH-1:0] peripheral_clock_enable,
  output mcl_pkg::mcl_mode_t power_mode,
  output logic clock_failure_signal,
  output logic slave_owns_pll_registers,
  output logic pll_write_accept,
  output logic main_pll_power_on,
  output logic usb_pll_power_on,
  output logic oscillator_power_on,
  output logic usb_pll_bypass,
  output logic [mcl_pkg::USB_MULT_W-1:0] usb_pll_multiplier_value
);
  import mcl_pkg::*;

  // ****************************************************************************
  // divider step
  // ****************************************************************************
  // divisor of zero or one passes every source edge through
  function automatic mcl_div_t div_step(
    input logic [DIV_W-1:0] cnt,
    input logic tick,
    input logic [DIV_W-1:0] divisor
  );
    mcl_div_t r;
    r.cnt = cnt;
    r.pulse = 1'b0;
    if (tick)
    begin
      if (divisor <= DIV_ONE || cnt >= divisor - DIV_ONE)
      begin
        r.cnt = '0;
        r.pulse = 1'b1;
      end
      else
      begin
        r.cnt = cnt + DIV_ONE;
      end
    end
    return r;
  endfunction : div_step

  // ****************************************************************************
  // can source pick
  // ****************************************************************************
  // select code 3 picks nothing, so the can clock simply stops
  function automatic logic can_pick(
    input logic [1:0] sel,
    input logic master,
    input logic osc,
    input logic aux
  );
    logic r;
    r = 1'b0;
    case (sel)
      MCL_CAN_MASTER: r = master;
      MCL_CAN_OSC: r = osc;
      MCL_CAN_AUX: r = aux;
      default: r = 1'b0;
    endcase
    return r;
  endfunction : can_pick

  // ****************************************************************************
  // peripheral gating
  // ****************************************************************************
  mcl_state_t s_r;
  mcl_state_t s_nxt;
  logic [N_PERIPH-1:0] gate_sel;

  // presence wins over every gating bit, so an absent block never sees an edge
  genvar gi;
  generate
    for (gi = 0; gi < N_PERIPH; gi++)
    begin : g_gate
      always_comb
      begin
        if (!device_configuration_presence[gi])
        begin
          gate_sel[gi] = 1'b0;
        end
        else if (s_r.mode == MCL_RUN || !auto_gating_select)
        begin
          gate_sel[gi] = run_peripheral_gating[gi];
        end
        else if (s_r.mode == MCL_SLEEP)
        begin
          gate_sel[gi] = sleep_peripheral_gating[gi];
        end
        else
        begin
          gate_sel[gi] = deep_sleep_peripheral_gating[gi];
        end
      end
    end
  endgenerate

  // ****************************************************************************
  // next state
  // ****************************************************************************
  mcl_div_t sys_d;
  mcl_div_t mst_d;
  mcl_div_t ana_d;
  mcl_div_t ds_d;
  mcl_div_t usb_d;
  logic sys_src_tick;
  logic sys_tick;
  logic ds_src_tick;
  logic mst_src_tick;
  logic deep;

  always_comb
  begin
    s_nxt = s_r;
    deep = (s_r.mode == MCL_DEEP);

    // ****************************************
    // missing-clock watch
    // ****************************************
    // fast ticks counted since the last oscillator edge
    // paused while the oscillator is deliberately off, so deep sleep is no false alarm
    if (ticks.oscillator)
    begin
      s_nxt.miss_cnt = '0;
    end
    else if (ticks.fast_osc && s_r.osc_on && !s_r.fail)
    begin
      s_nxt.miss_cnt = s_r.miss_cnt + 8'h01;
      if (s_nxt.miss_cnt >= MISS_FAST_TICKS)
      begin
        s_nxt.fail = 1'b1;
      end
    end

    // ****************************************
    // system clock
    // ****************************************
    // source picked by latched select, divided by system divider
    sys_src_tick = s_r.sys_sel_pll ? ticks.main_pll : ticks.oscillator;
    sys_d = div_step(s_r.sys_cnt, sys_src_tick, system_clock_divider_select);
    s_nxt.sys_cnt = sys_d.cnt;
    // select moves only while the divider sits at its boundary
    if (s_r.sys_cnt == '0 && !sys_src_tick)
    begin
      s_nxt.sys_sel_pll = main_pll_output_select;
    end
    // on failure the fast clock takes over whole, restarting the divider
    if (s_r.fail)
    begin
      sys_tick = ticks.fast_osc;
      s_nxt.sys_cnt = '0;
    end
    else
    begin
      sys_tick = sys_d.pulse;
    end

    // ****************************************
    // deep-sleep path
    // ****************************************
    case (s_r.ds_sel)
      MCL_DS_SLOW: ds_src_tick = ticks.slow_osc;
      MCL_DS_FAST: ds_src_tick = ticks.fast_osc;
      MCL_DS_OSC: ds_src_tick = ticks.oscillator;
      default: ds_src_tick = 1'b0;
    endcase
    // source latched on a deep divider boundary, never in a cycle that carries an edge from the current source
    if (s_r.ds_cnt == '0 && !ds_src_tick)
    begin
      s_nxt.ds_sel = deep_sleep_source_select;
    end
    ds_d = div_step(s_r.ds_cnt, ds_src_tick && deep, deep_sleep_divider);
    s_nxt.ds_cnt = ds_d.cnt;

    // ****************************************
    // master and analog dividers
    // ****************************************
    // master divider shared by run/sleep and deep sleep paths
    mst_src_tick = deep ? ds_d.pulse : sys_tick;
    mst_d = div_step(s_r.mst_cnt, mst_src_tick, master_clock_divider_select);
    s_nxt.mst_cnt = mst_d.cnt;

    ana_d = div_step(s_r.ana_cnt, sys_tick && !deep, analog_clock_divider_control);
    s_nxt.ana_cnt = ana_d.cnt;

    // ****************************************
    // usb clock
    // ****************************************
    // pll output divided by four, or the reference when bypassed
    usb_d = div_step(s_r.usb_cnt, ticks.usb_pll && !deep, USB_PLL_DIV);
    s_nxt.usb_cnt = usb_d.cnt;
    s_nxt.usb_mult = usb_pll_integer_multiplier;
    s_nxt.usb_bypass = (usb_pll_integer_multiplier == USB_MULT_BYPASS);

    // ****************************************
    // mode sequencing
    // ****************************************
    case (s_r.mode)
      MCL_RUN:
      begin
        if (s_r.isr_temp && isr_return)
        begin
          s_nxt.mode = s_r.return_mode;
          s_nxt.isr_temp = 1'b0;
        end
        else if (wait_for_interrupt)
        begin
          s_nxt.mode = deep_sleep_select_bit ? MCL_DEEP : MCL_SLEEP;
          s_nxt.isr_temp = 1'b0;
        end
      end
      MCL_SLEEP, MCL_DEEP:
      begin
        if (wake_interrupt)
        begin
          s_nxt.mode = MCL_RUN;
          s_nxt.return_mode = s_r.mode;
          s_nxt.isr_temp = sleep_on_exit_bit;
        end
      end
      default:
      begin
        s_nxt.mode = MCL_RUN;
      end
    endcase

    // a master source swap at a deep-sleep boundary restarts both counts, so the first period is whole
    if ((s_nxt.mode == MCL_DEEP) != deep)
    begin
      s_nxt.mst_cnt = '0;
      s_nxt.ds_cnt = '0;
    end

    // ****************************************
    // power controls
    // ****************************************
    // follow the mode being entered
    s_nxt.main_pll_on = (s_nxt.mode != MCL_DEEP);
    s_nxt.usb_pll_on = (s_nxt.mode != MCL_DEEP);
    s_nxt.osc_on = !(s_nxt.mode == MCL_DEEP && deep_sleep_source_select != MCL_DS_OSC);

    // ****************************************
    // write ownership of the main pll registers
    // ****************************************
    if (slave_write_ownership_request)
    begin
      s_nxt.owner_slave = 1'b1;
    end
    else if (master_write_ownership_request)
    begin
      s_nxt.owner_slave = 1'b0;
    end
    s_nxt.pll_wr_accept = s_r.owner_slave ? slave_pll_write : master_pll_write;

    // ****************************************
    // derived clock enables
    // ****************************************
    s_nxt.clk.main_system = sys_tick && !deep;
    s_nxt.clk.slave_and_shared = sys_tick && !deep;
    s_nxt.clk.master_subsystem = mst_d.pulse;
    s_nxt.clk.master_cpu = mst_d.pulse && (s_r.mode == MCL_RUN);
    s_nxt.clk.analog_subsystem = s_r.fail ? (ticks.fast_osc && !deep) : ana_d.pulse;
    s_nxt.clk.usb = (s_r.usb_bypass ? ticks.usb_ref : usb_d.pulse) && !deep;
    s_nxt.clk.first_watchdog = ticks.oscillator;
    // the can pick moves only in a cycle with no edge from the old or the new source
    if (!can_pick(s_r.can_sel, mst_d.pulse, ticks.oscillator, ticks.aux_in)
      && !can_pick(can_source_select, mst_d.pulse, ticks.oscillator, ticks.aux_in))
    begin
      s_nxt.can_sel = can_source_select;
    end
    s_nxt.clk.can = can_pick(s_r.can_sel, mst_d.pulse, ticks.oscillator, ticks.aux_in);
    // sleep keeps the run rate since the master divider path is unchanged
    s_nxt.periph = gate_sel & {N_PERIPH{mst_d.pulse}};
  end

  // ****************************************************************************
  // state register
  // ****************************************************************************
  always_ff @(posedge ref_clk)
  begin
    if (srst)
    begin
      // fields not named start at zero: master owns, no failure, counters clear
      s_r <= '0;
      s_r.mode <= MCL_RUN;
      s_r.return_mode <= MCL_RUN;
      s_r.sys_sel_pll <= 1'b0;
      s_r.can_sel <= MCL_CAN_MASTER;
      s_r.main_pll_on <= 1'b1;
      s_r.usb_pll_on <= 1'b1;
      s_r.osc_on <= 1'b1;
      s_r.usb_bypass <= 1'b1;
    end
    else
    begin
      s_r <= s_nxt;
    end
  end

  // ****************************************************************************
  // outputs
  // ****************************************************************************
  // plain flop copies, so no output has a combinational path from an input
  assign clocks = s_r.clk;
  assign peripheral_clock_enable = s_r.periph;
  assign power_mode = s_r.mode;
  assign clock_failure_signal = s_r.fail;
  assign slave_owns_pll_registers = s_r.owner_slave;
  assign pll_write_accept = s_r.pll_wr_accept;
  assign main_pll_power_on = s_r.main_pll_on;
  assign usb_pll_power_on = s_r.usb_pll_on;
  assign oscillator_power_on = s_r.osc_on;
  assign usb_pll_bypass = s_r.usb_bypass;
  assign usb_pll_multiplier_value = s_r.usb_mult;

endmodule : mcl_clock_lowpower

// >>> mcl_clock_lowpower_checker.sv
// port assertions for the master clock and low-power controller
`timescale 1ns/1ps
module mcl_clock_lowpower_checker
  import mcl_pkg::*;
(
  input wire logic ref_clk,
  input wire logic srst,
  input wire logic wait_for_interrupt,
  input wire logic wake_interrupt,
  input wire logic isr_return,
  input wire logic deep_sleep_select_bit,
  input wire logic [1:0] deep_sleep_source_select,
  input wire logic [mcl_pkg::N_PERIPH-1:0] device_configuration_presence,
  input wire logic slave_write_ownership_request,
  input wire logic [mcl_pkg::USB_MULT_W-1:0] usb_pll_integer_multiplier,
  input wire mcl_pkg::mcl_clocks_t clocks,
  input wire logic [mcl_pkg::N_PERIPH-1:0] peripheral_clock_enable,
  input wire mcl_pkg::mcl_mode_t power_mode,
  input wire logic slave_owns_pll_registers,
  input wire logic main_pll_power_on,
  input wire logic usb_pll_power_on,
  input wire logic oscillator_power_on,
  input wire logic usb_pll_bypass,
  input wire logic [mcl_pkg::USB_MULT_W-1:0] usb_pll_multiplier_value
);
  import mcl_pkg::*;
  // ****************************************
  // mode, gating and ownership properties
  // ****************************************
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (srst);
  sequence s_wfi;
    power_mode == MCL_RUN && wait_for_interrupt && !isr_return;
  endsequence
  sequence s_wake;
    power_mode != MCL_RUN && wake_interrupt;
  endsequence
  property p_wfi_mode;
    s_wfi |=> power_mode == ($past(deep_sleep_select_bit) ? MCL_DEEP : MCL_SLEEP);
  endproperty
  a_wfi_mode: assert property (p_wfi_mode) else $error("wfi went to wrong mode");
  property p_wake;
    s_wake |=> power_mode == MCL_RUN;
  endproperty
  a_wake: assert property (p_wake) else $error("wake did not return to run");
  property p_deep_off;
    power_mode == MCL_DEEP |-> !main_pll_power_on && !usb_pll_power_on;
  endproperty
  a_deep_off: assert property (p_deep_off) else $error("pll left on in deep sleep");
  // first deep cycle may still carry a pulse launched in run
  property p_deep_quiet;
    power_mode == MCL_DEEP && $past(power_mode) == MCL_DEEP |-> !clocks.main_system && !clocks.slave_and_shared
      && !clocks.analog_subsystem && !clocks.usb && !clocks.master_cpu;
  endproperty
  a_deep_quiet: assert property (p_deep_quiet) else $error("clock pulse in deep sleep");
  property p_osc_src;
    power_mode == MCL_DEEP && $stable(deep_sleep_source_select)
      |-> oscillator_power_on == (deep_sleep_source_select == 2'h2);
  endproperty
  a_osc_src: assert property (p_osc_src) else $error("oscillator power wrong in deep sleep");
  property p_cpu_run;
    clocks.master_cpu |-> power_mode == MCL_RUN || $past(power_mode) == MCL_RUN;
  endproperty
  a_cpu_run: assert property (p_cpu_run) else $error("cpu clock outside run");
  property p_present;
    (peripheral_clock_enable & ~(device_configuration_presence | $past(device_configuration_presence))) == 8'h00;
  endproperty
  a_present: assert property (p_present) else $error("absent peripheral clocked");
  property p_gate_master;
    |peripheral_clock_enable |-> clocks.master_subsystem;
  endproperty
  a_gate_master: assert property (p_gate_master) else $error("peripheral pulse off master clock");
  property p_owner;
    slave_write_ownership_request |=> slave_owns_pll_registers;
  endproperty
  a_owner: assert property (p_owner) else $error("slave request not granted");
  property p_usb_code;
    usb_pll_multiplier_value == $past(usb_pll_integer_multiplier)
      && usb_pll_bypass == (usb_pll_multiplier_value == USB_MULT_BYPASS);
  endproperty
  a_usb_code: assert property (p_usb_code) else $error("usb multiplier copy wrong");
endmodule : mcl_clock_lowpower_checker

bind mcl_clock_lowpower mcl_clock_lowpower_checker chk_i (.*);

// >>> mcl_source_model.sv
// source clocks seen as tick pulses: plls, oscillators, auxiliary input
`timescale 1ns/1ps
module mcl_source_model
  import mcl_pkg::*;
(
  input wire logic ref_clk,
  input wire logic main_pll_power_on,
  input wire logic usb_pll_power_on,
  input wire logic oscillator_power_on,
  input wire logic osc_dead,
  output mcl_pkg::mcl_ticks_t ticks
);
  import mcl_pkg::*;
  int n = 0;
  initial ticks = '0;
  // a powered-off source gives no edges at all
  always @(negedge ref_clk)
  begin
    n <= n + 1;
    ticks.main_pll <= main_pll_power_on && n % 2 == 0;
    ticks.oscillator <= oscillator_power_on && !osc_dead && n % 3 == 0;
    ticks.fast_osc <= n % 4 == 1;
    ticks.slow_osc <= n % 16 == 5;
    ticks.aux_in <= n % 5 == 2;
    ticks.usb_pll <= usb_pll_power_on && n % 2 == 1;
    ticks.usb_ref <= n % 3 == 1;
  end
endmodule : mcl_source_model

// >>> master_subsystem_clock_lowpower_test.sv
// self-checking bench for the master clock and low-power controller
`timescale 1ns/1ps
module master_subsystem_clock_lowpower_test;
  import mcl_pkg::*;
  logic ref_clk = 0, srst = 1, osc_dead = 0;
  mcl_ticks_t ticks;
  logic main_pll_output_select = 0, auto_gating_select = 0, deep_sleep_select_bit = 0, sleep_on_exit_bit = 0;
  logic [DIV_W-1:0] system_clock_divider_select = 6'h01, master_clock_divider_select = 6'h01;
  logic [DIV_W-1:0] analog_clock_divider_control = 6'h01, deep_sleep_divider = 6'h01;
  logic [1:0] deep_sleep_source_select = 2'h0, can_source_select = 2'h0;
  logic [USB_MULT_W-1:0] usb_pll_integer_multiplier = 6'h00;
  logic [N_PERIPH-1:0] run_peripheral_gating = 8'h0f, sleep_peripheral_gating = 8'h3c;
  logic [N_PERIPH-1:0] deep_sleep_peripheral_gating = 8'hf0, device_configuration_presence = 8'h5a;
  logic wait_for_interrupt = 0, wake_interrupt = 0, isr_return = 0;
  logic slave_write_ownership_request = 0, master_write_ownership_request = 0;
  logic master_pll_write = 0, slave_pll_write = 0;
  mcl_clocks_t clocks;
  logic [N_PERIPH-1:0] peripheral_clock_enable, seen;
  mcl_mode_t power_mode;
  logic clock_failure_signal, slave_owns_pll_registers, pll_write_accept;
  logic main_pll_power_on, usb_pll_power_on, oscillator_power_on, usb_pll_bypass;
  logic [USB_MULT_W-1:0] usb_pll_multiplier_value;
  int miscompares = 0, num_checks = 0, n_sys, n_mst, n_ana, d, m, a;
  int nt [7];
  int nc [8];
  logic slave_low_power_status = 0;
  mcl_clock_lowpower uut (.*);
  mcl_source_model src (.ref_clk, .main_pll_power_on, .usb_pll_power_on, .oscillator_power_on, .osc_dead, .ticks);
  initial forever #10 ref_clk = ~ref_clk;
  // ****************************************
  // shared tasks
  // ****************************************
  task automatic end_sim;
    $display("checks %0d mismatches %0d", num_checks, miscompares);
    if (miscompares == 0 && num_checks > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask : end_sim
  // counts allow a small slack for divider phase at the window edges
  task automatic chk(string what, logic [31:0] exp, logic [31:0] got, int tol = 0);
    num_checks++;
    if (tol == 0 ? got !== exp : (int'(got) > int'(exp) + tol || int'(got) + tol < int'(exp)))
    begin
      miscompares++;
      $display("mismatch %s expected %0h seen %0h", what, exp, got);
    end
  endtask : chk
  task automatic cyc(int n);
    repeat (n) @(negedge ref_clk);
  endtask : cyc
  task automatic pulse(ref logic s);
    s = 1;
    cyc(1);
    s = 0;
    cyc(1);
  endtask : pulse
  task automatic measure(int n);
    n_sys = 0;
    n_mst = 0;
    n_ana = 0;
    seen = '0;
    nt = '{default: 0};
    nc = '{default: 0};
    repeat (n) @(negedge ref_clk)
    begin
      for (int i = 0; i < 7; i++) nt[i] += ticks[i];
      for (int i = 0; i < 8; i++) nc[i] += (clocks[i] === 1'b1);
      n_sys += (clocks.main_system === 1'b1);
      n_mst += (clocks.master_subsystem === 1'b1);
      n_ana += (clocks.analog_subsystem === 1'b1);
      seen |= peripheral_clock_enable;
    end
    cyc(1);
  endtask : measure
  task automatic wr(ref logic s, input logic exp);
    logic acc;
    s = 1;
    cyc(1);
    s = 0;
    acc = pll_write_accept;
    cyc(1);
    acc |= pll_write_accept;
    chk("accept", exp, acc);
  endtask : wr
  initial
  begin
    #400000;
    miscompares++;
    end_sim();
  end
  // ****************************************
  // main sequence
  // ****************************************
  initial
  begin
    void'($urandom(32'h47a2));
    cyc(10);
    srst = 0;
    cyc(1);
    chk("mode", MCL_RUN, power_mode);
    chk("fail", 0, clock_failure_signal);
    chk("owner", 0, slave_owns_pll_registers);
    for (int i = 0; i < 4; i++)
    begin
      d = $urandom_range(1, 6);
      m = $urandom_range(1, 6);
      a = $urandom_range(1, 6);
      system_clock_divider_select = 6'(d);
      master_clock_divider_select = 6'(m);
      analog_clock_divider_control = 6'(a);
      main_pll_output_select = i[0];
      can_source_select = 2'(i % 3);
      cyc(80);
      measure(600);
      chk("sys", nt[i[0] ? 6 : 5] / d, n_sys, 2);
      chk("mst", nt[i[0] ? 6 : 5] / (d * m), n_mst, 2);
      chk("ana", nt[i[0] ? 6 : 5] / (d * a), n_ana, 2);
      chk("run gate", run_peripheral_gating & device_configuration_presence, seen);
      chk("can", i % 3 == 1 ? nt[5] : i % 3 == 2 ? nt[2] : nt[i[0] ? 6 : 5] / (d * m), nc[2], 2);
      chk("wdog", nt[5], nc[1], 2);
      chk("cpu", nt[i[0] ? 6 : 5] / (d * m), nc[4], 2);
      chk("shared", nt[i[0] ? 6 : 5] / d, nc[3], 2);
      chk("usb", nt[0], nc[0], 2);
    end
    auto_gating_select = 1;
    usb_pll_integer_multiplier = 6'h30;
    pulse(wait_for_interrupt);
    chk("sleep", MCL_SLEEP, power_mode);
    chk("pll on", 1, main_pll_power_on);
    measure(600);
    chk("sleep gate", sleep_peripheral_gating & device_configuration_presence, seen);
    chk("sleep mst", nt[6] / (d * m), n_mst, 2);
    chk("sleep cpu", 0, nc[4]);
    chk("sleep usb", nt[1] / 4, nc[0], 2);
    chk("sleep shared", nt[6] / d, nc[3], 2);
    pulse(wake_interrupt);
    chk("woke", MCL_RUN, power_mode);
    deep_sleep_select_bit = 1;
    for (int s = 0; s < 3; s++)
    begin
      deep_sleep_source_select = 2'(s);
      sleep_on_exit_bit = (s == 1);
      cyc(80);
      slave_low_power_status = 1;
      if (slave_low_power_status) pulse(wait_for_interrupt);
      chk("deep", MCL_DEEP, power_mode);
      chk("osc on", s == 2, oscillator_power_on);
      chk("plls", 0, main_pll_power_on | usb_pll_power_on);
      measure(700);
      chk("deep sys", 0, n_sys);
      chk("deep quiet", 0, nc[5] | nc[4] | nc[3] | nc[0]);
      chk("deep mst", nt[3 + s] / m, n_mst, 2);
      chk("deep gate", deep_sleep_peripheral_gating & device_configuration_presence, seen);
      pulse(wake_interrupt);
      chk("woke", MCL_RUN, power_mode);
      pulse(isr_return);
      chk("exit", s == 1 ? MCL_DEEP : MCL_RUN, power_mode);
      if (power_mode !== MCL_RUN) pulse(wake_interrupt);
    end
    sleep_on_exit_bit = 0;
    pulse(isr_return);
    chk("stay", MCL_RUN, power_mode);
    wr(master_pll_write, 1);
    pulse(slave_write_ownership_request);
    chk("owner", 1, slave_owns_pll_registers);
    wr(slave_pll_write, 1);
    wr(master_pll_write, 0);
    pulse(master_write_ownership_request);
    chk("owner", 0, slave_owns_pll_registers);
    wr(slave_pll_write, 0);
    for (int i = 0; i < 8; i++)
    begin
      usb_pll_integer_multiplier = i == 0 ? 6'h00 : i == 1 ? 6'h20 : i == 2 ? 6'h3f : 6'($urandom);
      cyc(2);
      chk("usb mult", usb_pll_integer_multiplier, usb_pll_multiplier_value);
      chk("usb bypass", usb_pll_integer_multiplier == 6'h00, usb_pll_bypass);
    end
    osc_dead = 1;
    cyc(60);
    chk("fail", 1, clock_failure_signal);
    measure(400);
    chk("fail sys", nt[4], n_sys, 2);
    chk("fail mst", nt[4] / m, n_mst, 2);
    chk("fail ana", nt[4], n_ana, 2);
    end_sim();
  end
endmodule : master_subsystem_clock_lowpower_test
